// ==== rom_pkg.sv ====
// Constants and types shared by the reference offset and margin register bank.
package rom_pkg;

  // Command codes of the three offset registers.
  localparam logic [7:0]  ROM_CODE_TRIM      = 8'hd4;
  localparam logic [7:0]  ROM_CODE_UP        = 8'hd5;
  localparam logic [7:0]  ROM_CODE_DOWN      = 8'hd6;

  // Reset and restore values.
  localparam logic [15:0] ROM_TRIM_RESET     = 16'h0000;
  localparam logic [15:0] ROM_UP_RESTORE0    = 16'h0009;
  localparam logic [15:0] ROM_UP_RESTORE1    = 16'h000f;
  localparam logic [15:0] ROM_DOWN_RESTORE0  = 16'hfff7;
  localparam logic [15:0] ROM_DOWN_RESTORE1  = 16'hfff1;

  // Allowed ranges, two's complement counts of one step.
  localparam logic [15:0] ROM_TRIM_MIN       = 16'hffc0;
  localparam logic [15:0] ROM_TRIM_MAX       = 16'h003f;
  localparam logic [15:0] ROM_UP_MIN         = 16'h0000;
  localparam logic [15:0] ROM_UP_MAX         = 16'h001f;
  localparam logic [15:0] ROM_DOWN_MIN       = 16'hffc0;
  localparam logic [15:0] ROM_DOWN_MAX       = 16'hffff;

  // Output data format: linear, exponent -9, one count is 1953 microvolts.
  localparam int          ROM_VOUT_EXP       = -9;
  localparam int          ROM_STEP_UV        = 1953;

  typedef enum logic [2:0] {
    ROM_PWR_OFF        = 3'b000,
    ROM_PWR_SOFT_START = 3'b001,
    ROM_PWR_STEADY     = 3'b010,
    ROM_PWR_TOFF_DELAY = 3'b011,
    ROM_PWR_SOFT_STOP  = 3'b100
  } rom_pwr_type;

  typedef enum logic [1:0] {
    ROM_MARGIN_NONE = 2'b00,
    ROM_MARGIN_HIGH = 2'b01,
    ROM_MARGIN_LOW  = 2'b10
  } rom_margin_type;

  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } rom_cmd_type;

  typedef struct packed {
    logic        ack;
    logic [15:0] data;
  } rom_rsp_type;

endpackage : rom_pkg

// ==== rom_regs.sv ====
// Offset and margin command registers driving the loop reference.
//
// Behaviour
// - Signed trim adds constant offset to reference.
// - Trim spans minus 64 to plus 63.
// - Out-of-range write clamps, alerts, flags errors.
// - Follower mode: ignore, refuse, fault, alert.
// - Format fixed linear, exponent minus nine.
// - Reference clamped to output limits; negative sum, off and soft stop give zero.
// - Slew rate follows power-up state.
// - Trim is two-byte signed, default zero.
// - Trim can be saved to nonvolatile memory.
// - Trim high byte sign-extends low byte.
// - Trim low byte minus 64 to 63.
// - Margin high raises reference by up step.
// - Up step 0 to 31, high byte zero.
// - Up step restores to 0009h or 000fh.
// - Margin low lowers reference by down step.
// - Down step minus 64 to minus 1.
// - Down step high byte sign-extends, all ones.
// - Down step restores to fff7h or fff1h.
// - Down low byte minus 64 to minus 1.
`timescale 1ns/1ps
`default_nettype none

module rom_regs (
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  input  wire logic                   cmd_valid,
  input  wire rom_pkg::rom_cmd_type   cmd,
  input  wire logic                   follower_mode,
  input  wire rom_pkg::rom_margin_type margin_sel,
  input  wire rom_pkg::rom_pwr_type   power_state,
  input  wire logic [15:0]            vout_command,
  input  wire logic [15:0]            vout_min,
  input  wire logic [15:0]            vout_max,
  input  wire logic [15:0]            rate_rise,
  input  wire logic [15:0]            rate_transition,
  input  wire logic [15:0]            rate_fall,
  input  wire logic                   restore_req,
  input  wire logic [15:0]            nvm_trim_value,
  input  wire logic                   margin_up_restore_sel,
  input  wire logic                   margin_down_restore_sel,
  input  wire logic                   store_all_req,
  output logic                        rsp_valid,
  output rom_pkg::rom_rsp_type        rsp,
  output logic [15:0]                 loop_reference,
  output logic                        smb_alert,
  output logic                        comm_error_flag,
  output logic                        invalid_data_flag,
  output logic                        bad_command_fault,
  output logic                        nvm_store_req,
  output logic [15:0]                 nvm_store_data
);

  logic [15:0] trim_r;
  logic [15:0] up_r;
  logic [15:0] down_r;
  logic [15:0] ref_r;
  logic [15:0] slew_cnt_r;
  logic        hit;
  logic        refused;
  logic        wr_ok;
  logic        out_of_range;
  logic [15:0] clamped;
  logic [15:0] target;
  logic [15:0] period;
  logic signed [17:0] sum;
  logic        sel_trim;
  logic        sel_up;
  logic        sel_down;
  logic        rd_ok;
  logic        range_evt;
  logic [15:0] rd_data;
  logic [15:0] restore_trim;
  logic [15:0] restore_up;
  logic [15:0] restore_down;
  logic        slew_due;
  logic        slew_up;
  logic signed [17:0] base_sum;
  logic signed [17:0] margin_add;
  logic signed [17:0] lo_bound;
  logic signed [17:0] hi_bound;

  function automatic logic [15:0] clamp_s(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    logic [15:0] r;
    r = v;
    if ($signed(v) < $signed(lo)) begin
      r = lo;
    end else if ($signed(v) > $signed(hi)) begin
      r = hi;
    end
    return r;
  endfunction : clamp_s

  // Other command codes belong to other blocks and get no answer here.
  assign sel_trim  = (cmd.code == rom_pkg::ROM_CODE_TRIM);
  assign sel_up    = (cmd.code == rom_pkg::ROM_CODE_UP);
  assign sel_down  = (cmd.code == rom_pkg::ROM_CODE_DOWN);
  assign hit       = cmd_valid && (sel_trim || sel_up || sel_down);
  assign refused   = hit && follower_mode;
  assign wr_ok     = hit && !follower_mode && cmd.write;
  assign rd_ok     = hit && !follower_mode && !cmd.write;
  assign range_evt = wr_ok && out_of_range;

  // Margin steps have no stored copy; option bits pick their restore value.
  always_comb begin
    restore_trim = clamp_s(nvm_trim_value, rom_pkg::ROM_TRIM_MIN,
                           rom_pkg::ROM_TRIM_MAX);
    if (margin_up_restore_sel) begin
      restore_up = rom_pkg::ROM_UP_RESTORE1;
    end else begin
      restore_up = rom_pkg::ROM_UP_RESTORE0;
    end
    if (margin_down_restore_sel) begin
      restore_down = rom_pkg::ROM_DOWN_RESTORE1;
    end else begin
      restore_down = rom_pkg::ROM_DOWN_RESTORE0;
    end
  end

  // Read data is chosen from the code alone; rd_ok gates it later.
  always_comb begin
    case (cmd.code)
      rom_pkg::ROM_CODE_TRIM: begin
        rd_data = trim_r;
      end
      rom_pkg::ROM_CODE_UP: begin
        rd_data = up_r;
      end
      rom_pkg::ROM_CODE_DOWN: begin
        rd_data = down_r;
      end
      default: begin
        rd_data = 16'h0000;
      end
    endcase
  end

  // Range check per register; a clamped value always sign-extends cleanly.
  always_comb begin
    case (cmd.code)
      rom_pkg::ROM_CODE_TRIM: begin
        clamped = clamp_s(cmd.data, rom_pkg::ROM_TRIM_MIN,
                          rom_pkg::ROM_TRIM_MAX);
      end
      rom_pkg::ROM_CODE_UP: begin
        clamped = clamp_s(cmd.data, rom_pkg::ROM_UP_MIN,
                          rom_pkg::ROM_UP_MAX);
      end
      default: begin
        clamped = clamp_s(cmd.data, rom_pkg::ROM_DOWN_MIN,
                          rom_pkg::ROM_DOWN_MAX);
      end
    endcase
    out_of_range = (clamped != cmd.data);
  end

  // Restore takes priority over a write in the same cycle.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      trim_r <= rom_pkg::ROM_TRIM_RESET;
    end else if (restore_req) begin
      trim_r <= restore_trim;
    end else if (wr_ok && sel_trim) begin
      trim_r <= clamped;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      up_r <= rom_pkg::ROM_UP_RESTORE0;
    end else if (restore_req) begin
      up_r <= restore_up;
    end else if (wr_ok && sel_up) begin
      up_r <= clamped;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      down_r <= rom_pkg::ROM_DOWN_RESTORE0;
    end else if (restore_req) begin
      down_r <= restore_down;
    end else if (wr_ok && sel_down) begin
      down_r <= clamped;
    end
  end

  // Answer one cycle after the request; a refused access is a nack.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= hit;
    end
  end

  // Writes and refused reads answer with zero data.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rsp <= '0;
    end else begin
      rsp.ack  <= hit && !follower_mode;
      rsp.data <= rd_ok ? rd_data : 16'h0000;
    end
  end

  // Error events are one-cycle pulses; the status block keeps them sticky.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      comm_error_flag   <= 1'b0;
      invalid_data_flag <= 1'b0;
    end else begin
      comm_error_flag   <= range_evt;
      invalid_data_flag <= range_evt;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      smb_alert         <= 1'b0;
      bad_command_fault <= 1'b0;
    end else begin
      bad_command_fault <= refused;
      smb_alert         <= refused || range_evt;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      nvm_store_req  <= 1'b0;
      nvm_store_data <= 16'h0000;
    end else begin
      nvm_store_req  <= store_all_req;
      nvm_store_data <= trim_r;
    end
  end

  // Counts are in units of 2^-9 V, so plain integer sums suffice.
  // Sums are kept in 18 bits so a negative total is caught, not wrapped.
  always_comb begin
    base_sum = $signed({2'b00, vout_command}) +
               $signed({{2{trim_r[15]}}, trim_r});
    case (margin_sel)
      rom_pkg::ROM_MARGIN_HIGH: begin
        margin_add = $signed({{2{up_r[15]}}, up_r});
      end
      rom_pkg::ROM_MARGIN_LOW: begin
        margin_add = $signed({{2{down_r[15]}}, down_r});
      end
      default: begin
        margin_add = 18'sh00000;
      end
    endcase
  end

  always_comb begin
    lo_bound = $signed({2'b00, vout_min});
    hi_bound = $signed({2'b00, vout_max});
    sum = base_sum + margin_add;
    if (sum < 18'sh00000) begin
      target = 16'h0000;
    end else if (sum > hi_bound) begin
      target = vout_max;
    end else if (sum < lo_bound) begin
      target = vout_min;
    end else begin
      target = sum[15:0];
    end
    if (power_state == rom_pkg::ROM_PWR_OFF ||
        power_state == rom_pkg::ROM_PWR_SOFT_STOP) begin
      target = 16'h0000;
    end
  end

  always_comb begin
    case (power_state)
      rom_pkg::ROM_PWR_SOFT_START: begin
        period = rate_rise;
      end
      rom_pkg::ROM_PWR_STEADY: begin
        period = rate_transition;
      end
      rom_pkg::ROM_PWR_TOFF_DELAY: begin
        period = rate_transition;
      end
      rom_pkg::ROM_PWR_SOFT_STOP: begin
        period = rate_fall;
      end
      default: begin
        period = 16'h0000;
      end
    endcase
  end

  // The wrap of period minus one at zero is never used; zero jumps.
  assign slew_due = (slew_cnt_r >= period - 16'h0001);
  assign slew_up  = (ref_r < target);

  // One count per period; a zero period steps straight to the target.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ref_r      <= 16'h0000;
      slew_cnt_r <= 16'h0000;
    end else if (period == 16'h0000) begin
      ref_r      <= target;
      slew_cnt_r <= 16'h0000;
    end else if (ref_r == target) begin
      slew_cnt_r <= 16'h0000;
    end else if (slew_due) begin
      slew_cnt_r <= 16'h0000;
      if (slew_up) begin
        ref_r <= ref_r + 16'h0001;
      end else begin
        ref_r <= ref_r - 16'h0001;
      end
    end else begin
      slew_cnt_r <= slew_cnt_r + 16'h0001;
    end
  end

  assign loop_reference = ref_r;

endmodule : rom_regs

`default_nettype wire

// ==== rom_regs_properties.sv ====
// Checker of the command port, error pulses and store request.
`timescale 1ns/1ps
`default_nettype none
module rom_regs_properties (
  input wire logic                 clk_sys,
  input wire logic                 nrst,
  input wire logic                 cmd_valid,
  input wire rom_pkg::rom_cmd_type cmd,
  input wire logic                 follower_mode,
  input wire logic                 store_all_req,
  input wire logic                 rsp_valid,
  input wire rom_pkg::rom_rsp_type rsp,
  input wire logic                 smb_alert,
  input wire logic                 comm_error_flag,
  input wire logic                 invalid_data_flag,
  input wire logic                 bad_command_fault,
  input wire logic                 nvm_store_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic hit, hitf, hitr;
  assign hit = cmd_valid && (cmd.code inside {8'hd4, 8'hd5, 8'hd6});
  assign hitf = hit && follower_mode;
  assign hitr = hit && !cmd.write && !follower_mode;
  sequence s_nack;
    rsp_valid && !rsp.ack && bad_command_fault && smb_alert;
  endsequence
  chk_answer_delay: assert property (hit |=> rsp_valid)
    else $error("answer missing one cycle after request");
  chk_no_stray: assert property (rsp_valid |-> $past(hit))
    else $error("answer without request");
  chk_follower_nack: assert property (hitf |=> s_nack)
    else $error("follower request not refused");
  chk_fault_cause: assert property (bad_command_fault |-> $past(hitf))
    else $error("fault without follower request");
  chk_range_flags: assert property (comm_error_flag |->
    invalid_data_flag && smb_alert && rsp.ack)
    else $error("range error flags incomplete");
  chk_read_clean: assert property (hitr |=>
    rsp.ack && !comm_error_flag && !bad_command_fault)
    else $error("read raised an error");
  chk_store_echo: assert property (store_all_req |=> nvm_store_req)
    else $error("store request not passed on");
  chk_store_cause: assert property (nvm_store_req |-> $past(store_all_req))
    else $error("store request without cause");
endmodule : rom_regs_properties
bind rom_regs rom_regs_properties chk_u (.*);
`default_nettype wire

// ==== rom_host.sv ====
// Host model that issues decoded register commands.
`timescale 1ns/1ps
`default_nettype none
module rom_host (
  input  wire logic            clk_sys,
  output logic                 cmd_valid,
  output rom_pkg::rom_cmd_type cmd
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // A released command word is inverted so stale values never pass.
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [15:0] d);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd <= '{w, c, d};
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd <= ~cmd;
    #1;
  endtask : xfer
endmodule : rom_host
`default_nettype wire

// ==== rom_tb.sv ====
// Self-checking testbench of the offset register bank.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0, nrst = 1'b0, follower_mode = 1'b0;
  logic restore_req = 1'b0, store_all_req = 1'b0, cmd_valid;
  logic margin_up_restore_sel = 1'b0, margin_down_restore_sel = 1'b0;
  rom_pkg::rom_cmd_type cmd;
  rom_pkg::rom_margin_type margin_sel = rom_pkg::ROM_MARGIN_NONE;
  rom_pkg::rom_pwr_type power_state = rom_pkg::ROM_PWR_STEADY;
  logic [15:0] vout_command = 16'h0100, vout_min = 16'h0000;
  logic [15:0] vout_max = 16'h0fff, rate_transition = 16'h0000;
  logic [15:0] rate_rise = 16'h0000, rate_fall = 16'h0000;
  logic [15:0] nvm_trim_value = 16'h0011, loop_reference, nvm_store_data;
  logic rsp_valid, smb_alert, comm_error_flag, invalid_data_flag;
  logic bad_command_fault, nvm_store_req;
  rom_pkg::rom_rsp_type rsp;
  int fails = 0, n_checks = 0, cyc = 0;
  rom_host host_u (.*);
  rom_regs dut_u (.*);
  always #2.5 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [23:0] e, g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    host_u.xfer(1'b0, c, 16'h0000);
    chk("read", {2'b11, e}, {rsp_valid, rsp.ack, rsp.data});
  endtask : rd
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic e);
    host_u.xfer(1'b1, c, d);
    chk("write", {2'b11, e, e, e, 16'h0000}, {rsp_valid, rsp.ack,
        smb_alert, comm_error_flag, invalid_data_flag, rsp.data});
  endtask : wr
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic t_reset();
    rd(8'hd4, 16'h0000);
    rd(8'hd5, 16'h0009);
    rd(8'hd6, 16'hfff7);
  endtask : t_reset
  task automatic t_ranges();
    logic [40:0] t [12] = '{
      {8'hd4, 16'hffc0, 16'hffc0, 1'b0}, {8'hd4, 16'h003f, 16'h003f, 1'b0},
      {8'hd4, 16'h0040, 16'h003f, 1'b1}, {8'hd4, 16'hffbf, 16'hffc0, 1'b1},
      {8'hd5, 16'h001f, 16'h001f, 1'b0}, {8'hd5, 16'h0000, 16'h0000, 1'b0},
      {8'hd5, 16'h0020, 16'h001f, 1'b1}, {8'hd5, 16'hffff, 16'h0000, 1'b1},
      {8'hd6, 16'hffc0, 16'hffc0, 1'b0}, {8'hd6, 16'hffff, 16'hffff, 1'b0},
      {8'hd6, 16'h0000, 16'hffff, 1'b1}, {8'hd6, 16'hffbf, 16'hffc0, 1'b1}};
    foreach (t[i]) begin
      wr(t[i][40:33], t[i][32:17], t[i][0]);
      rd(t[i][40:33], t[i][16:1]);
    end
  endtask : t_ranges
  task automatic t_follower();
    @(posedge clk_sys) follower_mode <= 1'b1;
    host_u.xfer(1'b1, 8'hd4, 16'h0010);
    chk("nack", 20'hb0000, {rsp_valid, rsp.ack, smb_alert,
        bad_command_fault, rsp.data});
    host_u.xfer(1'b0, 8'hd6, 16'h0000);
    chk("nack", 20'hb0000, {rsp_valid, rsp.ack, smb_alert,
        bad_command_fault, rsp.data});
    @(posedge clk_sys) follower_mode <= 1'b0;
    rd(8'hd4, 16'hffc0);
  endtask : t_follower
  task automatic t_ref();
    wr(8'hd4, 16'h0005, 1'b0);
    settle(3);
    chk("ref", 16'h0105, loop_reference);
    wr(8'hd5, 16'h0003, 1'b0);
    @(posedge clk_sys) margin_sel <= rom_pkg::ROM_MARGIN_HIGH;
    settle(3);
    chk("ref", 16'h0108, loop_reference);
    @(posedge clk_sys) vout_max <= 16'h0100;
    settle(3);
    chk("ref", 16'h0100, loop_reference);
    wr(8'hd6, 16'hfff0, 1'b0);
    @(posedge clk_sys) margin_sel <= rom_pkg::ROM_MARGIN_LOW;
    rate_transition <= 16'h0004;
    settle(3);
    chk("slow", 1, loop_reference > 16'h00f5);
    settle(60);
    chk("ref", 16'h00f5, loop_reference);
    @(posedge clk_sys) power_state <= rom_pkg::ROM_PWR_SOFT_START;
    wr(8'hd4, 16'h0006, 1'b0);
    settle(3);
    chk("ref", 16'h00f6, loop_reference);
  endtask : t_ref
  task automatic t_limits();
    @(posedge clk_sys) vout_min <= 16'h0100;
    settle(3);
    chk("ref", 16'h0100, loop_reference);
    @(posedge clk_sys) power_state <= rom_pkg::ROM_PWR_SOFT_STOP;
    rate_fall <= 16'h0002;
    settle(3);
    chk("stop", 16'h00ff, loop_reference);
  endtask : t_limits
  task automatic t_restore();
    @(posedge clk_sys) restore_req <= 1'b1;
    margin_up_restore_sel <= 1'b1;
    margin_down_restore_sel <= 1'b1;
    @(posedge clk_sys) restore_req <= 1'b0;
    rd(8'hd5, 16'h000f);
    rd(8'hd6, 16'hfff1);
    rd(8'hd4, 16'h0011);
    @(posedge clk_sys) store_all_req <= 1'b1;
    @(posedge clk_sys) store_all_req <= 1'b0;
    #1;
    chk("store", 17'h10011, {nvm_store_req, nvm_store_data});
  endtask : t_restore
  task automatic summarize();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // The ceiling is more than twenty times the length of the full sequence.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_ranges();
    t_follower();
    t_ref();
    t_limits();
    t_restore();
    summarize();
  end
endmodule : testbench
`default_nettype wire
